// ---- test/core_bus_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------
// core side of the i/o bus
// ---------------------------------------------
module core_bus_model (
	input  wire logic       core_clk,
	input  wire logic [3:0] ioRdData,
	output logic            ioOut,
	output logic            ioIn,
	output logic [3:0]      ioAddr,
	output logic [3:0]      ioWrData
);
	// bus idle at start
	initial begin
		ioOut = 1'h0;
		ioIn = 1'h0;
		ioAddr = 4'h0;
		ioWrData = 4'h0;
	end

	// one OUT, then released lines carry scrambled values
	task automatic wr(input logic [3:0] a, input logic [3:0] d);
		@(posedge core_clk);
		#1;
		ioOut = 1'h1;
		ioAddr = a;
		ioWrData = d;
		@(posedge core_clk);
		#1;
		ioOut = 1'h0;
		ioAddr = ~a;
		ioWrData = ~d;
	endtask

	// one IN, data taken in the cycle after the strobe edge
	task automatic rd(input logic [3:0] a, output logic [3:0] q);
		@(posedge core_clk);
		#1;
		ioIn = 1'h1;
		ioAddr = a;
		@(posedge core_clk);
		#1;
		ioIn = 1'h0;
		ioAddr = ~a;
		q = ioRdData;
	endtask
endmodule // core_bus_model

`default_nettype wire

// ---- test/io_periph_props.sv ----
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------
// decode checks at the top ports
// ---------------------------------------------
module io_periph_props (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       ioOut,
	input wire logic       ioIn,
	input wire logic [3:0] ioAddr,
	input wire logic [3:0] ioWrData,
	input wire logic [3:0] ioRdData,
	input wire logic [3:0] serialStatus,
	input wire logic [3:0] voltMonStatus,
	input wire logic [3:0] port1Latch,
	input wire logic       port1Drive,
	input wire logic [3:0] sysConfig,
	input wire logic [3:0] clockManagement,
	input wire logic [7:0] port4Control,
	input wire logic [3:0] timer3Control,
	input wire logic       watchdogClear,
	input wire logic       serialTxLoad
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [23:0] cfg;

	// registers that unrelated traffic must leave alone
	assign cfg = {sysConfig, clockManagement, port4Control, timer3Control, port1Latch};

	a_serst_read: assert property (ioIn && ioAddr == 4'hA |=> ioRdData == $past(serialStatus))
		else $error("status read wrong");
	a_vmon_read: assert property (ioIn && ioAddr == 4'hF ##1 1'h1 |-> ioRdData == $past(voltMonStatus))
		else $error("monitor read wrong");
	a_wdog_read: assert property (ioIn && ioAddr == 4'h3 |=> watchdogClear && ioRdData == 4'hF)
		else $error("watchdog read wrong");
	a_wdog_cause: assert property ($rose(watchdogClear) |-> $past(ioIn) && $past(ioAddr) == 4'h3)
		else $error("stray watchdog clear");
	a_t3ctl_write: assert property (ioOut && ioAddr == 4'hC |=> timer3Control == $past(ioWrData))
		else $error("timer3 control not written");
	a_port1_out: assert property (ioOut && ioAddr == 4'h1 |=> port1Drive && port1Latch == $past(ioWrData))
		else $error("port1 write wrong");
	a_port1_in: assert property (ioIn && ioAddr == 4'h1 |=> !port1Drive)
		else $error("port1 not input");
	a_resv_quiet: assert property (ioOut && (ioAddr == 4'hD || ioAddr == 4'hE) |=> $stable(cfg))
		else $error("reserved write had effect");
	a_auxsw_quiet: assert property (ioOut && ioAddr == 4'h8 |=> $stable(cfg))
		else $error("aux switch write leaked");
	a_rd_hold: assert property (!ioIn |=> $stable(ioRdData))
		else $error("read data changed");
	a_txload_cause: assert property (serialTxLoad |-> $past(ioOut) && $past(ioAddr) == 4'h9)
		else $error("stray transmit load");

	c_txload: cover property (serialTxLoad);
	c_wdog: cover property (watchdogClear);
	c_resv: cover property (ioOut && ioAddr == 4'hD);
endmodule // io_periph_props

bind io_peripheral_addressing io_periph_props u_props (
	.core_clk(core_clk), .rst_n(rst_n), .ioOut(ioOut), .ioIn(ioIn),
	.ioAddr(ioAddr), .ioWrData(ioWrData), .ioRdData(ioRdData),
	.serialStatus(serialStatus), .voltMonStatus(voltMonStatus),
	.port1Latch(port1Latch), .port1Drive(port1Drive), .sysConfig(sysConfig),
	.clockManagement(clockManagement), .port4Control(port4Control),
	.timer3Control(timer3Control), .watchdogClear(watchdogClear),
	.serialTxLoad(serialTxLoad)
);

`default_nettype wire

// ---- test/io_peripheral_addressing_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module io_peripheral_addressing_tb_top;
	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	logic         core_clk, rst_n, ioOut, ioIn, port1Drive, watchdogClear, serialTxLoad;
	logic [3:0]   ioAddr, ioWrData, ioRdData, got;
	logic [3:0]   port1Pin, port2Pin, port4Pin, port5Pin, port6Pin;
	logic [3:0]   serialStatus, timer3Status, voltMonStatus;
	logic [7:0]   serialRxData, timer3Capture, serialTxBuffer, port4Control, port5Control;
	logic [3:0]   port1Latch, port2Latch, port2Direction, port4Latch, port5Latch;
	logic [3:0]   port6Latch, port6Control, sysConfig, clockManagement, serialControl1;
	logic [3:0]   serialStatusControl, serialControl2, timer3Control, voltMonControl;
	logic [127:0] timer12Regs, timer3Regs, snap;
	wire logic [63:0] prim;
	int           n_fail = 0;
	int           tests_run = 0;

	typedef struct packed {logic w; logic [3:0] a; logic [3:0] d;} row_s;
	// write rows give the data, read rows the expected nibble
	localparam row_s ROWS [19] = '{
		'{1'h1, 4'h1, 4'h3}, '{1'h1, 4'h2, 4'h5}, '{1'h1, 4'h3, 4'h6}, '{1'h1, 4'h4, 4'h9},
		'{1'h1, 4'h5, 4'hA}, '{1'h1, 4'h6, 4'hC}, '{1'h1, 4'hA, 4'h3}, '{1'h1, 4'hC, 4'h7},
		'{1'h1, 4'hF, 4'hE}, '{1'h0, 4'h1, 4'h1}, '{1'h0, 4'h2, 4'h2}, '{1'h0, 4'h4, 4'h4},
		'{1'h0, 4'h5, 4'h5}, '{1'h0, 4'h6, 4'h6}, '{1'h0, 4'hA, 4'h7}, '{1'h0, 4'hC, 4'h3},
		'{1'h0, 4'hF, 4'h8}, '{1'h0, 4'hD, 4'hF}, '{1'h0, 4'h8, 4'hF}};

	// primary write targets indexed by module address
	assign prim = {voltMonControl, 8'h00, timer3Control, 4'h0, serialStatusControl, 12'h000,
		port6Latch, port5Latch, port4Latch, sysConfig, port2Latch, port1Latch, 4'h0};

	io_peripheral_addressing DUT (
		.core_clk, .rst_n, .ioOut, .ioIn, .ioAddr, .ioWrData, .ioRdData,
		.port1Pin, .port2Pin, .port4Pin, .port5Pin, .port6Pin,
		.serialRxData, .serialStatus, .timer3Capture, .timer3Status, .voltMonStatus,
		.port1Latch, .port1Drive, .port2Latch, .port2Direction, .port4Latch,
		.port4Control, .port5Latch, .port5Control, .port6Latch, .port6Control,
		.sysConfig, .clockManagement, .watchdogClear, .serialTxBuffer, .serialTxLoad,
		.serialControl1, .serialStatusControl, .serialControl2, .timer3Control,
		.voltMonControl, .timer12Regs, .timer3Regs
	);

	core_bus_model core (.core_clk, .ioRdData, .ioOut, .ioIn, .ioAddr, .ioWrData);

	// ---------------------------------------------
	// reporting
	// ---------------------------------------------
	task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// 10 MHz clock
	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		conclude();
	end

	// main sequence
	initial begin
		rst_n = 1'h0;
		{port1Pin, port2Pin, port4Pin, port5Pin, port6Pin} = 20'h1_2456;
		{serialStatus, timer3Status, voltMonStatus} = 12'h738;
		serialRxData = 8'hB4;
		timer3Capture = 8'h6E;
		repeat (5) @(posedge core_clk);
		#1;
		rst_n = 1'h1;
		foreach (ROWS[i]) begin
			if (ROWS[i].w) begin
				core.wr(ROWS[i].a, ROWS[i].d);
				check("primary", prim[{ROWS[i].a, 2'h0} +: 4], ROWS[i].d);
			end else begin
				core.rd(ROWS[i].a, got);
				check("readback", got, ROWS[i].d);
			end
		end
		$display("done: table");
		rst_n = 1'h0;
		repeat (5) @(posedge core_clk);
		#1;
		rst_n = 1'h1;
		check("ones", {port2Direction, port4Control, port5Control, port6Control, sysConfig,
			clockManagement, serialControl1, serialControl2, voltMonControl,
			serialStatusControl, port1Latch, port2Latch, port4Latch, port5Latch,
			port6Latch}, {68{1'h1}});
		check("misc", {timer3Control, port1Drive, ioRdData}, 9'h00F);
		check("t12rst", timer12Regs, io_periph_pkg::T12_RESETS);
		check("t3rst", timer3Regs, io_periph_pkg::T3_RESETS);
		$display("done: reset");
		core.wr(4'h8, 4'h4);
		core.wr(4'h4, 4'h5);
		core.wr(4'h4, 4'hA);
		check("p4ctl", port4Control, 8'hA5);
		core.wr(4'h4, 4'h7);
		check("p4back", {port4Control, port4Latch}, 12'hA57);
		core.wr(4'h8, 4'h3);
		core.wr(4'h3, 4'h6);
		check("clkmgmt", {clockManagement, sysConfig}, 8'h6F);
		core.wr(4'h8, 4'h9);
		core.wr(4'h9, 4'h5);
		core.wr(4'h8, 4'hA);
		core.wr(4'hA, 4'h6);
		check("serctl", {serialControl1, serialControl2}, 8'h56);
		core.wr(4'h9, 4'h2);
		core.wr(4'h9, 4'h7);
		check("txbuf", serialTxBuffer, 8'h72);
		check("txload", serialTxLoad, 1'h1);
		core.rd(4'h9, got);
		check("rxlo", got, 4'h4);
		core.rd(4'h9, got);
		check("rxhi", got, 4'hB);
		core.rd(4'h3, got);
		check("wdog", got, 4'hF);
		check("wdclr", watchdogClear, 1'h1);
		// auxiliary control registers of ports 5, 2 and 6
		core.wr(4'h8, 4'h5);
		core.wr(4'h5, 4'h3);
		core.wr(4'h5, 4'hC);
		core.wr(4'h8, 4'h2);
		core.wr(4'h2, 4'h6);
		core.wr(4'h8, 4'h6);
		core.wr(4'h6, 4'h9);
		check("auxctl", {port5Control, port2Direction, port6Control, port2Latch, port6Latch},
			24'hC3_69FF);
		$display("done: aux and serial");
		core.wr(4'h7, 4'h5);
		core.wr(4'h7, 4'hC);
		core.wr(4'h7, 4'h3);
		core.wr(4'h7, 4'h8);
		core.wr(4'h7, 4'h2);
		check("t12", {timer12Regs[71:64], timer12Regs[47:40]}, 16'h023C);
		snap = timer12Regs;
		core.wr(4'h7, 4'hB);
		core.wr(4'h7, 4'h1);
		check("t12rsv", timer12Regs, snap);
		core.wr(4'hB, 4'h4);
		core.wr(4'hB, 4'h1);
		core.wr(4'hB, 4'h9);
		check("t3cmp", timer3Regs[39:32], 8'h91);
		core.wr(4'hB, 4'h4);
		core.rd(4'hB, got);
		check("caplo", got, 4'hE);
		core.rd(4'hB, got);
		check("caphi", got, 4'h6);
		snap = {64'h0, prim};
		core.wr(4'hD, 4'h5);
		check("resv", prim, snap);
		$display("done: subports");
		conclude();
	end
endmodule // io_peripheral_addressing_tb_top

`default_nettype wire

// ---- verilog/io_periph_pkg.sv ----
package io_periph_pkg;

	// ----------------------------------------------------------------
	// module addresses on the i/o bus
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_PORT1  = 4'h1;
	localparam logic [3:0] ADDR_PORT2  = 4'h2;
	localparam logic [3:0] ADDR_SYSCFG = 4'h3;
	localparam logic [3:0] ADDR_PORT4  = 4'h4;
	localparam logic [3:0] ADDR_PORT5  = 4'h5;
	localparam logic [3:0] ADDR_PORT6  = 4'h6;
	localparam logic [3:0] ADDR_T12SP  = 4'h7;
	localparam logic [3:0] ADDR_AUXSW  = 4'h8;
	localparam logic [3:0] ADDR_SERBUF = 4'h9;
	localparam logic [3:0] ADDR_SERSC  = 4'hA;
	localparam logic [3:0] ADDR_T3SP   = 4'hB;
	localparam logic [3:0] ADDR_T3CTL  = 4'hC;
	localparam logic [3:0] ADDR_VMON   = 4'hF;

	// ----------------------------------------------------------------
	// subport slots with special handling
	// ----------------------------------------------------------------
	localparam logic [3:0] SUB_T3_CAPTURE = 4'h4;

	// ----------------------------------------------------------------
	// reset values (undefined bits reset to one)
	// ----------------------------------------------------------------
	localparam logic [3:0] RST_NIB_ONES  = 4'hF;
	localparam logic [3:0] RST_NIB_ZERO  = 4'h0;
	localparam logic [7:0] RST_BYTE_ONES = 8'hFF;
	localparam logic [3:0] READ_FILL     = 4'hF;

	// timer 1/2 bank: slot i occupies bits [8i+7:8i]
	localparam logic [127:0] T12_RESETS   = 128'h0000_0000_000F_0F0F_0000_FF0F_000F_0F00;
	localparam logic [15:0]  T12_BYTEMASK = 16'h0020;
	localparam logic [15:0]  T12_VALID    = 16'h073F;
	// timer 3 bank
	localparam logic [127:0] T3_RESETS    = 128'h0000_0000_0000_0000_0000_FFFF_0000_0F0F;
	localparam logic [15:0]  T3_BYTEMASK  = 16'h0030;
	localparam logic [15:0]  T3_VALID     = 16'h003F;

endpackage

// ---- verilog/io_peripheral_addressing.sv ----
// Functional notes
// - decoder reaches up to sixteen modules by the four-bit module address.
// - plain IN or OUT reaches the module's primary register.
// - writing module address to aux switch steers next access to that module to auxiliary.
// - byte registers move as two nibble accesses, low nibble first.
// - complex modules hold sixteen subport registers selected by sub-address.
// - first OUT loads sub-address; next access transfers subport data.
// - module 7 is write-only timer 1/2 subport bank, listed slots.
// - timer 3 slot 4 writes compare 1, reads return capture byte.
// - module B is timer 3 subport bank, slots 0-5 used.
// - module 9 writes transmit byte, reads receive byte; aux control 1.
// - module A primary is serial status/control; aux is control 2.
// - port 1 writes output latches, reads input pins, resets to ones.
// - ports 2,4,5,6 data read pins; aux holds direction/control registers.
// - module C writes timer 3 control, reads timer 3 status.
// - module F writes voltage control, reads status; D and E reserved.
`timescale 1ns/10ps
`default_nettype none

module io_peripheral_addressing (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// core i/o bus
	input  wire logic         ioOut,
	input  wire logic         ioIn,
	input  wire logic [3:0]   ioAddr,
	input  wire logic [3:0]   ioWrData,
	output logic [3:0]        ioRdData,
	// port pins (asynchronous)
	input  wire logic [3:0]   port1Pin,
	input  wire logic [3:0]   port2Pin,
	input  wire logic [3:0]   port4Pin,
	input  wire logic [3:0]   port5Pin,
	input  wire logic [3:0]   port6Pin,
	// peripheral state
	input  wire logic [7:0]   serialRxData,
	input  wire logic [3:0]   serialStatus,
	input  wire logic [7:0]   timer3Capture,
	input  wire logic [3:0]   timer3Status,
	input  wire logic [3:0]   voltMonStatus,
	// peripheral controls
	output logic [3:0]        port1Latch,
	output logic              port1Drive,
	output logic [3:0]        port2Latch,
	output logic [3:0]        port2Direction,
	output logic [3:0]        port4Latch,
	output logic [7:0]        port4Control,
	output logic [3:0]        port5Latch,
	output logic [7:0]        port5Control,
	output logic [3:0]        port6Latch,
	output logic [3:0]        port6Control,
	output logic [3:0]        sysConfig,
	output logic [3:0]        clockManagement,
	output logic              watchdogClear,
	output logic [7:0]        serialTxBuffer,
	output logic              serialTxLoad,
	output logic [3:0]        serialControl1,
	output logic [3:0]        serialStatusControl,
	output logic [3:0]        serialControl2,
	output logic [3:0]        timer3Control,
	output logic [3:0]        voltMonControl,
	output logic [127:0]      timer12Regs,
	output logic [127:0]      timer3Regs
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] pickNibble(input logic [7:0] b, input logic hi);
		pickNibble = hi ? b[7:4] : b[3:0];
	endfunction

	function automatic logic [7:0] putNibble(input logic [7:0] b, input logic [3:0] n,
		input logic hi);
		putNibble = hi ? {n, b[3:0]} : {b[7:4], n};
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [19:0] pinMeta;
	logic [19:0] pinSync;

	// two flops before any logic sees the pins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta <= '0;
			pinSync <= '0;
		end else begin
			pinMeta <= {port6Pin, port5Pin, port4Pin, port2Pin, port1Pin};
			pinSync <= pinMeta;
		end
	end

	// ----------------------------------------------------------------
	// steering state
	// ----------------------------------------------------------------
	logic [3:0] auxSwitch;
	logic       auxArmed;
	logic       nibbleHigh;
	logic       t12Phase;
	logic [3:0] t12SubAddr;
	logic       t3Phase;
	logic [3:0] t3SubAddr;
	logic [7:0] readHold;

	logic       access;
	logic       useAux;
	logic       t12Data;
	logic       t3Data;
	logic       byteTarget;
	logic       complete;

	// decode of the current access
	always_comb begin
		access  = ioOut || ioIn;
		useAux  = auxArmed && (ioAddr == auxSwitch) && (ioAddr != io_periph_pkg::ADDR_AUXSW);
		t12Data = (ioAddr == io_periph_pkg::ADDR_T12SP) && t12Phase;
		t3Data  = (ioAddr == io_periph_pkg::ADDR_T3SP) && t3Phase;
		byteTarget = 1'b0;
		if (useAux) begin
			byteTarget = (ioAddr == io_periph_pkg::ADDR_PORT4) ||
				(ioAddr == io_periph_pkg::ADDR_PORT5);
		end else if (ioAddr == io_periph_pkg::ADDR_SERBUF) begin
			byteTarget = 1'b1;
		end else if (t12Data) begin
			byteTarget = io_periph_pkg::T12_BYTEMASK[t12SubAddr];
		end else if (t3Data) begin
			byteTarget = io_periph_pkg::T3_BYTEMASK[t3SubAddr];
		end
		complete = !byteTarget || nibbleHigh;
	end

	// nibble sequencing of byte-wide locations
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nibbleHigh <= 1'b0;
		end else if (access) begin
			nibbleHigh <= byteTarget && !nibbleHigh;
		end
	end

	// aux switch and one-shot auxiliary steering
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			auxSwitch <= io_periph_pkg::RST_NIB_ONES;
			auxArmed  <= 1'b0;
		end else if (ioOut && ioAddr == io_periph_pkg::ADDR_AUXSW) begin
			auxSwitch <= ioWrData;
			auxArmed  <= 1'b1;
		end else if (access && useAux && complete) begin
			auxArmed  <= 1'b0;
		end
	end

	// subport address phases
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			t12Phase   <= 1'b0;
			t12SubAddr <= '0;
			t3Phase    <= 1'b0;
			t3SubAddr  <= '0;
		end else begin
			if (ioOut && ioAddr == io_periph_pkg::ADDR_T12SP && !t12Phase) begin
				t12SubAddr <= ioWrData;
				t12Phase   <= 1'b1;
			end else if (access && t12Data && complete) begin
				t12Phase   <= 1'b0;
			end
			if (ioOut && ioAddr == io_periph_pkg::ADDR_T3SP && !t3Phase) begin
				t3SubAddr <= ioWrData;
				t3Phase   <= 1'b1;
			end else if (access && t3Data && complete) begin
				t3Phase   <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// subport banks
	// ----------------------------------------------------------------
	subport_if t12Bus ();
	subport_if t3Bus ();

	// write requests into the banks; timer 1/2 is write only
	always_comb begin
		t12Bus.wr   = ioOut && t12Data;
		t12Bus.hi   = nibbleHigh;
		t12Bus.addr = t12SubAddr;
		t12Bus.data = ioWrData;
		t3Bus.wr    = ioOut && t3Data;
		t3Bus.hi    = nibbleHigh;
		t3Bus.addr  = t3SubAddr;
		t3Bus.data  = ioWrData;
	end

	subport_bank #(
		.RESETS   (io_periph_pkg::T12_RESETS),
		.BYTEMASK (io_periph_pkg::T12_BYTEMASK),
		.VALID    (io_periph_pkg::T12_VALID)
	) timer12Bank (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.sp       (t12Bus),
		.regs     (timer12Regs)
	);

	subport_bank #(
		.RESETS   (io_periph_pkg::T3_RESETS),
		.BYTEMASK (io_periph_pkg::T3_BYTEMASK),
		.VALID    (io_periph_pkg::T3_VALID)
	) timer3Bank (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.sp       (t3Bus),
		.regs     (timer3Regs)
	);

	// ----------------------------------------------------------------
	// primary and auxiliary register writes
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port1Latch          <= io_periph_pkg::RST_NIB_ONES;
			port2Latch          <= io_periph_pkg::RST_NIB_ONES;
			port2Direction      <= io_periph_pkg::RST_NIB_ONES;
			port4Latch          <= io_periph_pkg::RST_NIB_ONES;
			port4Control        <= io_periph_pkg::RST_BYTE_ONES;
			port5Latch          <= io_periph_pkg::RST_NIB_ONES;
			port5Control        <= io_periph_pkg::RST_BYTE_ONES;
			port6Latch          <= io_periph_pkg::RST_NIB_ONES;
			port6Control        <= io_periph_pkg::RST_NIB_ONES;
			sysConfig           <= io_periph_pkg::RST_NIB_ONES;
			clockManagement     <= io_periph_pkg::RST_NIB_ONES;
			serialTxBuffer      <= io_periph_pkg::RST_BYTE_ONES;
			serialControl1      <= io_periph_pkg::RST_NIB_ONES;
			serialStatusControl <= io_periph_pkg::RST_NIB_ONES;
			serialControl2      <= io_periph_pkg::RST_NIB_ONES;
			timer3Control       <= io_periph_pkg::RST_NIB_ZERO;
			voltMonControl      <= io_periph_pkg::RST_NIB_ONES;
		end else if (ioOut) begin
			unique case (ioAddr)
				io_periph_pkg::ADDR_PORT1: begin
					port1Latch <= ioWrData;
				end
				io_periph_pkg::ADDR_PORT2: begin
					if (useAux) port2Direction <= ioWrData;
					else port2Latch <= ioWrData;
				end
				io_periph_pkg::ADDR_SYSCFG: begin
					if (useAux) clockManagement <= ioWrData;
					else sysConfig <= ioWrData;
				end
				io_periph_pkg::ADDR_PORT4: begin
					if (useAux) port4Control <= putNibble(port4Control, ioWrData, nibbleHigh);
					else port4Latch <= ioWrData;
				end
				io_periph_pkg::ADDR_PORT5: begin
					if (useAux) port5Control <= putNibble(port5Control, ioWrData, nibbleHigh);
					else port5Latch <= ioWrData;
				end
				io_periph_pkg::ADDR_PORT6: begin
					if (useAux) port6Control <= ioWrData;
					else port6Latch <= ioWrData;
				end
				io_periph_pkg::ADDR_SERBUF: begin
					if (useAux) serialControl1 <= ioWrData;
					else serialTxBuffer <= putNibble(serialTxBuffer, ioWrData, nibbleHigh);
				end
				io_periph_pkg::ADDR_SERSC: begin
					if (useAux) serialControl2 <= ioWrData;
					else serialStatusControl <= ioWrData;
				end
				io_periph_pkg::ADDR_T3CTL: begin
					timer3Control <= ioWrData;
				end
				io_periph_pkg::ADDR_VMON: begin
					voltMonControl <= ioWrData;
				end
				default: begin
					// subport, aux switch and reserved D/E handled elsewhere or ignored
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// side effects: port 1 direction, watchdog clear, transmit load
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port1Drive <= 1'b0;
		end else if (access && ioAddr == io_periph_pkg::ADDR_PORT1) begin
			port1Drive <= ioOut;
		end
	end

	// one-cycle strobes toward watchdog and serial transmitter
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdogClear <= 1'b0;
			serialTxLoad  <= 1'b0;
		end else begin
			watchdogClear <= ioIn && ioAddr == io_periph_pkg::ADDR_SYSCFG && !useAux;
			serialTxLoad  <= ioOut && ioAddr == io_periph_pkg::ADDR_SERBUF && !useAux &&
				nibbleHigh;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ioRdData <= io_periph_pkg::READ_FILL;
			readHold <= '0;
		end else if (ioIn) begin
			ioRdData <= io_periph_pkg::READ_FILL;
			unique case (ioAddr)
				io_periph_pkg::ADDR_PORT1: begin
					ioRdData <= pinSync[3:0];
				end
				io_periph_pkg::ADDR_PORT2: begin
					if (!useAux) ioRdData <= pinSync[7:4];
				end
				io_periph_pkg::ADDR_PORT4: begin
					if (!useAux) ioRdData <= pinSync[11:8];
				end
				io_periph_pkg::ADDR_PORT5: begin
					if (!useAux) ioRdData <= pinSync[15:12];
				end
				io_periph_pkg::ADDR_PORT6: begin
					if (!useAux) ioRdData <= pinSync[19:16];
				end
				io_periph_pkg::ADDR_SERBUF: begin
					if (!useAux && !nibbleHigh) begin
						readHold <= serialRxData;
						ioRdData <= serialRxData[3:0];
					end else if (!useAux) begin
						ioRdData <= pickNibble(readHold, 1'b1);
					end
				end
				io_periph_pkg::ADDR_SERSC: begin
					if (!useAux) ioRdData <= serialStatus;
				end
				io_periph_pkg::ADDR_T3SP: begin
					if (t3Data && t3SubAddr == io_periph_pkg::SUB_T3_CAPTURE) begin
						if (!nibbleHigh) begin
							readHold <= timer3Capture;
							ioRdData <= timer3Capture[3:0];
						end else begin
							ioRdData <= pickNibble(readHold, 1'b1);
						end
					end
				end
				io_periph_pkg::ADDR_T3CTL: begin
					ioRdData <= timer3Status;
				end
				io_periph_pkg::ADDR_VMON: begin
					ioRdData <= voltMonStatus;
				end
				default: begin
					// write-only, watchdog-clear and reserved reads return the fill value
				end
			endcase
		end
	end

endmodule // io_peripheral_addressing

`default_nettype wire

// ---- verilog/subport_bank.sv ----
`timescale 1ns/10ps
`default_nettype none

// bank of sixteen byte-wide subport registers behind one module address; only BYTEMASK slots take both nibbles
module subport_bank #(
	parameter logic [127:0] RESETS   = '0,
	parameter logic [15:0]  BYTEMASK = '0,
	parameter logic [15:0]  VALID    = '0
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	subport_if.bank           sp,
	output logic [127:0]      regs
);

	// ----------------------------------------------------------------
	// slot write: byte slots take low then high nibble
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			regs <= RESETS;
		end else if (sp.wr && VALID[sp.addr]) begin
			if (BYTEMASK[sp.addr] && sp.hi) begin
				regs[{sp.addr, 3'b100} +: 4] <= sp.data;
			end else begin
				regs[{sp.addr, 3'b000} +: 4] <= sp.data;
			end
		end
	end

endmodule // subport_bank

`default_nettype wire

// ---- verilog/subport_if.sv ----
`timescale 1ns/10ps
`default_nettype none

// write channel from the decoder into one subport bank
interface subport_if;
	logic       wr;
	logic       hi;
	logic [3:0] addr;
	logic [3:0] data;

	modport ctrl (output wr, output hi, output addr, output data);
	modport bank (input wr, input hi, input addr, input data);
endinterface // subport_if

`default_nettype wire
